// *** bit_shift_flag_ops.sv ***
// bit, shift and flag instruction datapath with its register file, reached over APB
// assumes an APB master on clk_sys; reset_n may be asynchronous to clk_sys
`timescale 1ns/1ps

package bit_shift_pkg;
	localparam int         APB_AW       = 8;
	localparam int         REG_AW       = 5;
	localparam int         REG_DEPTH    = 32;
	localparam logic [7:0] OFS_INSTR    = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_REG_ADDR = 8'h08;
	localparam logic [7:0] OFS_REG_DATA = 8'h0c;
	localparam int         OP_LSB       = 0;
	localparam int         RD_LSB       = 4;
	localparam int         SRC_LSB      = 9;
	localparam int         BIT_LSB      = 14;
	localparam int         FLAG_C       = 0;
	localparam int         FLAG_Z       = 1;
	localparam int         FLAG_N       = 2;
	localparam int         FLAG_V       = 3;
	localparam int         FLAG_T       = 6;
	localparam logic [7:0] STATUS_RST   = 8'h00;
	localparam logic [4:0] REGADDR_RST  = 5'h00;
	localparam logic [3:0] OP_NOP       = 4'h0;
	localparam logic [3:0] OP_ROT_RC    = 4'h1;
	localparam logic [3:0] OP_ASHIFT_R  = 4'h2;
	localparam logic [3:0] OP_SWAP      = 4'h3;
	localparam logic [3:0] OP_STAT_SET  = 4'h4;
	localparam logic [3:0] OP_STAT_CLR  = 4'h5;
	localparam logic [3:0] OP_TO_XFER   = 4'h6;
	localparam logic [3:0] OP_FROM_XFER = 4'h7;
	localparam logic [3:0] OP_CARRY_SET = 4'h8;
	localparam logic [3:0] OP_CARRY_CLR = 4'h9;
	localparam logic [3:0] OP_NEG_SET   = 4'ha;
	localparam logic [3:0] OP_NEG_CLR   = 4'hb;
endpackage

// Functional notes
// RULE1: rotate_right_carry: old carry to bit 7, bits shift down, bit 0 to carry; Z,C,N,V
// RULE2: arith_shift_right: bits 0..6 take next higher bit, bit 7 kept; Z,C,N,V
// RULE3: nibble swap exchanges high and low halves, no flag change, one cycle
// RULE4: status_bit_set writes one, status_bit_clear writes zero, only selected status bit
// RULE5: reg_bit_to_transfer copies selected source_register bit into transfer flag only
// RULE6: transfer_to_reg_bit copies transfer flag into selected destination bit, flags kept
// RULE7: carry_force_one sets carry, carry_force_zero clears it, one cycle, carry only
// RULE8: negative_force_one sets negative, negative_force_zero clears it, nothing else
// RULE9: result and flags written back together in one execute cycle
module bit_shift_flag_ops
	import bit_shift_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [7:0]        status_register
);

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_DONE} phase_e;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = 8'h01 << sel;
	endfunction

	function automatic logic is_mapped(input logic [APB_AW-1:0] a);
		is_mapped = (a == OFS_INSTR) || (a == OFS_STATUS) || (a == OFS_REG_ADDR) || (a == OFS_REG_DATA);
	endfunction

	// ****************************************
	// reset release
	// ****************************************
	logic [1:0] rst_sync_ff;
	logic       rst_n;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			rst_sync_ff <= 2'b00;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	// ****************************************
	// transfer capture
	// ****************************************
	phase_e              phase_ff;
	logic                wr_ff;
	logic [APB_AW-1:0]   ofs_ff;
	logic [31:0]         wdata_ff;
	logic [REG_AW-1:0]   addr_a_ff;
	logic [REG_AW-1:0]   addr_b_ff;
	logic [REG_AW-1:0]   regaddr_ff;
	logic                start;
	logic [7:0]          rd_val;
	logic [7:0]          src_val;

	assign start = psel && penable && (phase_ff == ST_IDLE);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			phase_ff <= ST_IDLE;
		else
		begin
			unique case (phase_ff)
				ST_IDLE:  if (start) phase_ff <= ST_FETCH;
				ST_FETCH: phase_ff <= ST_EXEC;
				ST_EXEC:  phase_ff <= ST_DONE; // [RULE9]
				ST_DONE:  phase_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ff     <= 1'b0;
			ofs_ff    <= '0;
			wdata_ff  <= '0;
			addr_a_ff <= '0;
			addr_b_ff <= '0;
		end
		else if (start)
		begin
			wr_ff     <= pwrite;
			ofs_ff    <= paddr;
			wdata_ff  <= pwdata;
			// register window uses the pointer, instructions carry their own indices
			addr_a_ff <= (paddr == OFS_INSTR) ? pwdata[RD_LSB +: REG_AW] : regaddr_ff;
			addr_b_ff <= pwdata[SRC_LSB +: REG_AW];
		end
	end

	// ****************************************
	// execute
	// ****************************************
	logic [3:0]  op;
	logic [2:0]  bsel;
	logic        exec_instr;
	logic [7:0]  nxt_status;
	logic [7:0]  result;
	logic        wr_en;
	logic        nxt_err;
	logic [31:0] nxt_rdata;

	assign op         = wdata_ff[OP_LSB +: 4];
	assign bsel       = wdata_ff[BIT_LSB +: 3];
	assign exec_instr = (phase_ff == ST_EXEC) && wr_ff && (ofs_ff == OFS_INSTR);

	always_comb
	begin
		nxt_status = status_register;
		result     = rd_val;
		wr_en      = 1'b0;
		nxt_err    = 1'b0;
		if (exec_instr)
		begin
			case (op)
				OP_NOP: ;
				OP_ROT_RC, OP_ASHIFT_R:
				begin
					result             = {(op == OP_ROT_RC) ? status_register[FLAG_C] : rd_val[7], rd_val[7:1]}; // [RULE1] [RULE2]
					wr_en              = 1'b1;
					nxt_status[FLAG_C] = rd_val[0];
					nxt_status[FLAG_N] = result[7];
					nxt_status[FLAG_Z] = (result == 8'h00);
					nxt_status[FLAG_V] = result[7] ^ rd_val[0]; // [RULE1] [RULE2]
				end
				OP_SWAP:
				begin
					result = {rd_val[3:0], rd_val[7:4]}; // [RULE3]
					wr_en  = 1'b1;
				end
				OP_STAT_SET: nxt_status = status_register | bit_mask(bsel); // [RULE4]
				OP_STAT_CLR: nxt_status = status_register & ~bit_mask(bsel); // [RULE4]
				OP_TO_XFER:  nxt_status[FLAG_T] = src_val[bsel]; // [RULE5]
				OP_FROM_XFER:
				begin
					result = status_register[FLAG_T] ? (rd_val | bit_mask(bsel)) : (rd_val & ~bit_mask(bsel)); // [RULE6]
					wr_en  = 1'b1;
				end
				OP_CARRY_SET: nxt_status[FLAG_C] = 1'b1; // [RULE7]
				OP_CARRY_CLR: nxt_status[FLAG_C] = 1'b0; // [RULE7]
				OP_NEG_SET:   nxt_status[FLAG_N] = 1'b1; // [RULE8]
				OP_NEG_CLR:   nxt_status[FLAG_N] = 1'b0; // [RULE8]
				default: nxt_err = 1'b1;
			endcase
		end
		else if (phase_ff == ST_EXEC)
		begin
			if (!is_mapped(ofs_ff))
				nxt_err = 1'b1;
			else if (wr_ff && ofs_ff == OFS_STATUS)
				nxt_status = wdata_ff[7:0];
			else if (wr_ff && ofs_ff == OFS_REG_DATA)
			begin
				result = wdata_ff[7:0];
				wr_en  = 1'b1;
			end
		end
	end

	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (!wr_ff)
		begin
			case (ofs_ff)
				OFS_STATUS:   nxt_rdata = {24'h00_0000, status_register};
				OFS_REG_ADDR: nxt_rdata = {27'h000_0000, regaddr_ff};
				OFS_REG_DATA: nxt_rdata = {24'h00_0000, rd_val};
				default:      nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	regfile_mem #(
		.DEPTH (REG_DEPTH),
		.WIDTH (8),
		.AW    (REG_AW)
	) u_regs (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.wr_en     (wr_en),
		.wr_addr   (addr_a_ff),
		.wr_data   (result),
		.rd_addr_a (addr_a_ff),
		.rd_data_a (rd_val),
		.rd_addr_b (addr_b_ff),
		.rd_data_b (src_val)
	);

	// ****************************************
	// state and bus answer
	// ****************************************
	// flags and register result land on the same edge
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			status_register <= STATUS_RST;
		else if (phase_ff == ST_EXEC)
			status_register <= nxt_status; // [RULE9]
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			regaddr_ff <= REGADDR_RST;
		else if (phase_ff == ST_EXEC && wr_ff && ofs_ff == OFS_REG_ADDR)
			regaddr_ff <= wdata_ff[REG_AW-1:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (phase_ff == ST_EXEC)
		begin
			pready  <= 1'b1;
			pslverr <= nxt_err;
			prdata  <= nxt_rdata;
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_rot_carry_in: assert property (exec_instr && op == OP_ROT_RC |=> // [RULE1]
		status_register[FLAG_C] == $past(rd_val[0]) && status_register[FLAG_N] == $past(status_register[FLAG_C]))
		else $error("rotate did not move carry correctly");
	a_ashift_top_kept: assert property (exec_instr && op == OP_ASHIFT_R |-> // [RULE2]
		wr_en && result[7] == rd_val[7] && result[6:0] == rd_val[7:1] ##1 status_register[FLAG_C] == $past(rd_val[0]))
		else $error("arithmetic shift result wrong");
	a_swap_no_flags: assert property (exec_instr && op == OP_SWAP |-> // [RULE3]
		result == {rd_val[3:0], rd_val[7:4]} ##1 ($stable(status_register) && pready))
		else $error("swap changed flags or took too long");
	a_stat_set_bit: assert property (exec_instr && op == OP_STAT_SET |=> // [RULE4]
		status_register == ($past(status_register) | (8'h01 << $past(bsel))))
		else $error("status bit set wrong");
	a_stat_clr_bit: assert property (exec_instr && op == OP_STAT_CLR |=> // [RULE4]
		status_register == ($past(status_register) & ~(8'h01 << $past(bsel))))
		else $error("status bit clear wrong");
	a_xfer_store: assert property (exec_instr && op == OP_TO_XFER |=> // [RULE5]
		status_register[FLAG_T] == $past(src_val[bsel]) && (status_register & 8'hbf) == ($past(status_register) & 8'hbf))
		else $error("bit store to transfer flag wrong");
	a_xfer_load: assert property (exec_instr && op == OP_FROM_XFER |-> // [RULE6]
		wr_en && result[bsel] == status_register[FLAG_T] && ((result ^ rd_val) & ~(8'h01 << bsel)) == 8'h00
		##1 $stable(status_register))
		else $error("bit load from transfer flag wrong");
	a_carry_forced: assert property (exec_instr && (op == OP_CARRY_SET || op == OP_CARRY_CLR) |=> // [RULE7]
		status_register[FLAG_C] == ($past(op) == OP_CARRY_SET) && status_register[7:1] == $past(status_register[7:1]))
		else $error("carry force wrong");
	a_neg_forced: assert property (exec_instr && (op == OP_NEG_SET || op == OP_NEG_CLR) |=> // [RULE8]
		status_register[FLAG_N] == ($past(op) == OP_NEG_SET) && (status_register & 8'hfb) == ($past(status_register) & 8'hfb))
		else $error("negative force wrong");
	a_exec_one_cycle: assert property (start |=> phase_ff == ST_FETCH ##1 phase_ff == ST_EXEC ##1 pready) // [RULE9]
		else $error("instruction did not complete in time");

	c_rot_done:  cover property (exec_instr && op == OP_ROT_RC ##1 pready);
	c_load_done: cover property (exec_instr && op == OP_FROM_XFER ##1 pready);
	c_bad_addr:  cover property (pready && pslverr);
	c_back2back: cover property (pready ##[1:3] start);

endmodule

// *** regfile_mem.sv ***
// general register file of the bit/shift datapath: one write port, two read ports
// assumes a single clock; read data come from registers, one cycle after the address
`timescale 1ns/1ps

module regfile_mem
#(
	parameter int DEPTH = 32,
	parameter int WIDTH = 8,
	parameter int AW    = $clog2(DEPTH)
)
(
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr_a,
	output logic      [WIDTH-1:0] rd_data_a,
	input  wire logic [AW-1:0]    rd_addr_b,
	output logic      [WIDTH-1:0] rd_data_b
);

	// ****************************************
	// parameter check
	// ****************************************
	if (DEPTH < 2 || (1 << AW) < DEPTH || WIDTH < 1)
	begin : g_bad_param
		$error("regfile_mem: unsupported depth or width");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];

	// array has no reset: contents are undefined until software writes them
	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
		begin
			mem_ff[wr_addr] <= wr_data;
		end
	end

	// read during write returns the old word
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_data_a <= '0;
			rd_data_b <= '0;
		end
		else
		begin
			rd_data_a <= mem_ff[rd_addr_a];
			rd_data_b <= mem_ff[rd_addr_b];
		end
	end

endmodule

// *** tb_top.sv ***
// self-checking bench for the bit, shift and flag datapath, driven over APB
// assumes bit_shift_pkg is compiled first and the slave answers within 20 access cycles
`timescale 1ns/1ps

module tb_top
	import bit_shift_pkg::*;
;
	logic              clk_sys;
	logic              reset_n;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [APB_AW-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [7:0]        status_register;
	int                miscompares = 0;
	int                checked = 0;

	bit_shift_flag_ops u_dut (
		.clk_sys         (clk_sys),
		.reset_n         (reset_n),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.paddr           (paddr),
		.pwdata          (pwdata),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.status_register (status_register)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask

	// request held until pready is sampled high; read data taken at that edge
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			$display("[ERR] pready expected 1 seen timeout");
			miscompares++;
			close_out();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// source and destination share one index so one preset serves both
	task automatic op_only(input logic [3:0] op, input logic [4:0] rd, input logic [2:0] bn,
		input logic [7:0] xd, input logic [7:0] xs);
		logic [31:0] r;
		logic        e;
		apb(1'b1, OFS_INSTR, 32'(op) | (32'(rd) << RD_LSB) | (32'(rd) << SRC_LSB) | (32'(bn) << BIT_LSB), r, e);
		chk("instr_err", 32'h0, {31'h0, e});
		apb(1'b0, OFS_REG_DATA, 32'h0, r, e);
		chk("reg_data", {24'h0, xd}, r);
		apb(1'b0, OFS_STATUS, 32'h0, r, e);
		chk("status", {24'h0, xs}, r);
		chk("status_pin", {24'h0, xs}, {24'h0, status_register});
	endtask

	task automatic run_op(input logic [3:0] op, input logic [4:0] rd, input logic [2:0] bn,
		input logic [7:0] din, input logic [7:0] sin, input logic [7:0] xd, input logic [7:0] xs);
		logic [31:0] r;
		logic        e;
		apb(1'b1, OFS_REG_ADDR, {27'h0, rd}, r, e);
		apb(1'b1, OFS_REG_DATA, {24'h0, din}, r, e);
		apb(1'b1, OFS_STATUS, {24'h0, sin}, r, e);
		op_only(op, rd, bn, xd, xs);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		logic [31:0] r;
		logic        e;
		chk("status_pin_rst", {24'h0, STATUS_RST}, {24'h0, status_register});
		apb(1'b0, OFS_STATUS, 32'h0, r, e);
		chk("status_rst", {24'h0, STATUS_RST}, r);
	endtask

	task automatic t_rotate;
		run_op(OP_ROT_RC, 5'd3, 3'd0, 8'h81, 8'h01, 8'hc0, 8'h05);
		op_only(OP_ROT_RC, 5'd3, 3'd0, 8'he0, 8'h0c);
		run_op(OP_ROT_RC, 5'd31, 3'd0, 8'h01, 8'h30, 8'h00, 8'h3b);
	endtask

	task automatic t_ashift;
		run_op(OP_ASHIFT_R, 5'd0, 3'd0, 8'h80, 8'h00, 8'hc0, 8'h0c);
		run_op(OP_ASHIFT_R, 5'd0, 3'd0, 8'h01, 8'h41, 8'h00, 8'h4b);
		run_op(OP_ASHIFT_R, 5'd5, 3'd0, 8'h7e, 8'h0f, 8'h3f, 8'h00);
	endtask

	task automatic t_swap;
		run_op(OP_SWAP, 5'd12, 3'd0, 8'h3c, 8'ha5, 8'hc3, 8'ha5);
		op_only(OP_SWAP, 5'd12, 3'd0, 8'h3c, 8'ha5);
		op_only(OP_NOP, 5'd12, 3'd0, 8'h3c, 8'ha5);
	endtask

	task automatic t_status_bits;
		for (int b = 0; b < 8; b++)
		begin
			run_op(OP_STAT_SET, 5'd9, 3'(b), 8'h55, 8'h00, 8'h55, 8'h01 << b);
			run_op(OP_STAT_CLR, 5'd9, 3'(b), 8'h55, 8'hff, 8'h55, ~(8'h01 << b));
		end
	endtask

	task automatic t_transfer;
		run_op(OP_TO_XFER, 5'd7, 3'd2, 8'ha5, 8'h00, 8'ha5, 8'h40);
		run_op(OP_TO_XFER, 5'd7, 3'd1, 8'ha5, 8'hff, 8'ha5, 8'hbf);
		run_op(OP_FROM_XFER, 5'd8, 3'd5, 8'h00, 8'h40, 8'h20, 8'h40);
		run_op(OP_FROM_XFER, 5'd8, 3'd0, 8'hff, 8'hbf, 8'hfe, 8'hbf);
	endtask

	task automatic t_carry_neg;
		run_op(OP_CARRY_SET, 5'd1, 3'd0, 8'h33, 8'h00, 8'h33, 8'h01);
		run_op(OP_CARRY_CLR, 5'd1, 3'd0, 8'h33, 8'hff, 8'h33, 8'hfe);
		run_op(OP_NEG_SET, 5'd1, 3'd0, 8'h33, 8'h00, 8'h33, 8'h04);
		run_op(OP_NEG_CLR, 5'd1, 3'd0, 8'h33, 8'hff, 8'h33, 8'hfb);
	endtask

	// illegal opcodes and an unmapped offset must answer an error and change nothing
	task automatic t_refuse;
		logic [31:0] r;
		logic        e;
		apb(1'b1, OFS_STATUS, 32'h5a, r, e);
		for (int op = 12; op < 16; op++)
		begin
			apb(1'b1, OFS_INSTR, 32'(op), r, e);
			chk("illegal_err", 32'h1, {31'h0, e});
		end
		apb(1'b1, 8'h10, 32'hff, r, e);
		chk("unmapped_wr_err", 32'h1, {31'h0, e});
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk("unmapped_rd_err", 32'h1, {31'h0, e});
		apb(1'b0, OFS_STATUS, 32'h0, r, e);
		chk("status_kept", 32'h5a, r);
	endtask

	initial
	begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset();
		t_rotate();
		t_ashift();
		t_swap();
		t_status_bits();
		t_transfer();
		t_carry_neg();
		t_refuse();
		close_out();
	end
endmodule
